// ==== nvsram_host_regs.svh ====
/*
 Timing counts, pin widths and sequence constants for the NV SRAM host controller.
 Assumes a 40 MHz ref_clk; included by clock_image_mem and nvsram_host by bare name.
*/
`ifndef NVSRAM_HOST_REGS_SVH
`define NVSRAM_HOST_REGS_SVH
// Notes on behaviour
// - Host holds address through write cycle
// - Host waits write recovery before next cycle
// - Host keeps output enable high on writes
// - Host uses one scratch location
// - Eight 8-bit registers, whole bytes moved
`define ADDR_W 21
`define DATA_W 8
`define SCRATCH_LIMIT 21'h07FFFF
`define PATTERN_BITS 64
`define CLOCK_REGS 8
`define HOURS_MODE_BIT 7
`define HOURS_PM_BIT 5
`define CLK_PERIOD_NS 25
`define ADDRESS_ACCESS_TIME_NS 100
`define WRITE_PULSE_TIME_NS 75
`define WRITE_RECOVERY_TIME_NS 10
`define WRITE_OUTPUT_DISABLE_TIME_NS 40
`define ACCESS_CYC ((`ADDRESS_ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define WPULSE_CYC ((`WRITE_PULSE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOV_CYC ((`WRITE_RECOVERY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ODW_CYC ((`WRITE_OUTPUT_DISABLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== nvsram_host_pkg.sv ====
/*
 Types for the NV SRAM host controller.
 Assumes nvsram_host_regs.svh is on the include path.
*/
package nvsram_host_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_STROBE = 3'b011,
		ST_RECOVER = 3'b010,
		ST_DONE = 3'b110
	} bus_state_t;
	typedef enum logic [1:0] {
		OP_MEM_READ = 2'h0,
		OP_MEM_WRITE = 2'h1,
		OP_CLOCK_READ = 2'h2,
		OP_CLOCK_WRITE = 2'h3
	} host_op_t;
	typedef enum logic [1:0] {
		SEQ_NONE = 2'h0,
		SEQ_OPEN = 2'h1,
		SEQ_PATTERN = 2'h2,
		SEQ_XFER = 2'h3
	} seq_phase_t;
endpackage

// ==== clock_image_mem.sv ====
/*
 Eight-byte image of the timekeeper registers held by the host.
 Registered read data; one write port, one read port, same clock.
*/
`timescale 1ns/1ps
`include "nvsram_host_regs.svh"
module clock_image_mem #(
	parameter int DEPTH = `CLOCK_REGS
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Write port
	input wire logic wr_en,
	input wire logic [2:0] wr_idx,
	input wire logic [7:0] wr_data,
	// Read port
	input wire logic [2:0] rd_idx,
	output logic [7:0] rd_data_ff
);
	logic [7:0] mem_ff [DEPTH];
	logic [7:0] nxt_rd_data;
	if (DEPTH != 8) begin : g_bad_depth
		$error("clock_image_mem: depth must be 8");
	end
	always_comb begin
		nxt_rd_data = mem_ff[rd_idx];
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_data_ff <= 8'h00;
		end else begin
			rd_data_ff <= nxt_rd_data;
		end
	end
	// No reset on the array: contents are defined by the caller before use
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem_ff[wr_idx] <= wr_data;
		end
	end
endmodule

// ==== nvsram_host.sv ====
/*
 Host controller for an asynchronous byte-wide NV SRAM with a hidden timekeeper.
 Runs memory reads and writes, and the unlock/transfer sequence for the timekeeper:
 one read, 64 pattern writes on the serial bit lane, then 64 transfer cycles.
 Assumes the device pins are joined directly; the data bus is resolved outside.
*/
`timescale 1ns/1ps
`include "nvsram_host_regs.svh"
module nvsram_host
	import nvsram_host_pkg::*;
#(
	parameter logic [63:0] UNLOCK_PATTERN = 64'h5CA33AC55CA33AC5,
	parameter logic [20:0] SCRATCH_ADDR = 21'h000000,
	parameter int ACCESS_CYCLES = `ACCESS_CYC,
	parameter int PULSE_CYCLES = `WPULSE_CYC,
	parameter int RECOVER_CYCLES = `RECOV_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// User request
	input wire logic req_valid,
	input wire host_op_t req_op,
	input wire logic [20:0] req_addr,
	input wire logic [7:0] req_wdata,
	input wire logic [63:0] clock_wdata,
	output logic req_ready_ff,
	output logic resp_valid_ff,
	output logic [7:0] resp_rdata_ff,
	output logic [63:0] clock_rdata_ff,
	output logic resp_blocked_ff,
	// Power-fail indication, asynchronous; synchronised inside
	input wire logic power_fail_threshold,
	// Device pins
	output logic chip_sel_n_ff,
	output logic write_en_n_ff,
	output logic out_en_n_ff,
	output logic [20:0] byte_address_lines_ff,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out_ff,
	output logic data_oe_ff
);
	// Strobe counters are eight bits wide, so no count may exceed 256
	if (ACCESS_CYCLES < 1 || PULSE_CYCLES < 1 || RECOVER_CYCLES < 1 ||
		ACCESS_CYCLES > 256 || PULSE_CYCLES > 256 || RECOVER_CYCLES > 256) begin : g_bad_counts
		$error("nvsram_host: cycle counts must lie between 1 and 256");
	end
	if (SCRATCH_ADDR > `SCRATCH_LIMIT) begin : g_bad_scratch
		$error("nvsram_host: scratch address must be in the lowest 512 kB");
	end

	bus_state_t st_ff, nxt_st;
	seq_phase_t ph_ff, nxt_ph;
	host_op_t op_ff, nxt_op;
	logic [7:0] cnt_ff, nxt_cnt;
	logic [6:0] bit_ff, nxt_bit;
	logic [63:0] shift_ff, nxt_shift;
	logic [20:0] addr_ff, nxt_addr;
	logic [7:0] wdata_ff, nxt_wdata;
	logic is_write_ff, nxt_is_write;
	logic nxt_ready;
	logic nxt_cs_n, nxt_we_n, nxt_oe_n, nxt_dq_oe, nxt_valid, nxt_blocked;
	logic [7:0] nxt_dout, nxt_rdata;
	logic [63:0] nxt_crdata;
	logic img_wr;
	logic [7:0] img_rd;
	logic pf_meta_ff, pf_ff;

	// two-stage synchroniser; only the second stage is used
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pf_meta_ff <= 1'b1;
			pf_ff <= 1'b1;
		end else begin
			pf_meta_ff <= power_fail_threshold;
			pf_ff <= pf_meta_ff;
		end
	end

	// Each byte read in a transfer goes into the image at index bit_ff[5:3]; write transfers store the zero-filled shift_ff[63:56]; the read port is unused
	assign img_wr = (ph_ff == SEQ_XFER) && (st_ff == ST_DONE) && (bit_ff[2:0] == 3'h7);
	clock_image_mem #(.DEPTH(`CLOCK_REGS)) u_img (
		.ref_clk(ref_clk),
		.rst(rst),
		.wr_en(img_wr),
		.wr_idx(bit_ff[5:3]),
		.wr_data(shift_ff[63:56]),
		.rd_idx(3'h0),
		.rd_data_ff(img_rd)
	);

	always_comb begin
		nxt_st = st_ff;
		nxt_ph = ph_ff;
		nxt_op = op_ff;
		nxt_cnt = cnt_ff;
		nxt_bit = bit_ff;
		nxt_shift = shift_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_is_write = is_write_ff;
		nxt_ready = 1'b0;
		nxt_cs_n = chip_sel_n_ff;
		nxt_we_n = write_en_n_ff;
		nxt_oe_n = out_en_n_ff;
		nxt_dq_oe = data_oe_ff;
		nxt_dout = data_out_ff;
		nxt_valid = 1'b0;
		nxt_blocked = resp_blocked_ff;
		nxt_rdata = resp_rdata_ff;
		nxt_crdata = clock_rdata_ff;
		case (st_ff)
			ST_IDLE: begin
				nxt_ready = 1'b1;
				if (req_valid && req_ready_ff) begin
					nxt_ready = 1'b0;
					nxt_op = req_op;
					if (pf_ff) begin
						// no pin activity while power is failing
						nxt_valid = 1'b1;
						nxt_blocked = 1'b1;
					end else begin
						nxt_blocked = 1'b0;
						nxt_st = ST_SETUP;
						nxt_cnt = 8'h00;
						if (req_op == OP_MEM_READ || req_op == OP_MEM_WRITE) begin
							nxt_ph = SEQ_NONE;
							nxt_addr = req_addr;
							nxt_wdata = req_wdata;
							nxt_is_write = (req_op == OP_MEM_WRITE);
						end else begin
							// opening read restarts the device pointer
							nxt_ph = SEQ_OPEN;
							nxt_addr = SCRATCH_ADDR;
							nxt_is_write = 1'b0;
							nxt_shift = clock_wdata;
						end
					end
				end
			end
			ST_SETUP: begin
				// address set one cycle before select, held to the end
				nxt_cs_n = 1'b0;
				nxt_cnt = 8'h00;
				if (is_write_ff) begin
					nxt_oe_n = 1'b1;
					nxt_we_n = 1'b0;
					nxt_dq_oe = 1'b1;
				end else begin
					nxt_oe_n = 1'b0;
					nxt_we_n = 1'b1;
					nxt_dq_oe = 1'b0;
				end
				nxt_st = ST_STROBE;
			end
			ST_STROBE: begin
				nxt_cnt = cnt_ff + 8'h01;
				if ({24'h0, cnt_ff} + 32'd1 >= (is_write_ff ? PULSE_CYCLES : ACCESS_CYCLES)) begin
					// chip select and whichever strobe is low (write or output enable) rise together, ending the read or write
					nxt_we_n = 1'b1;
					nxt_cs_n = 1'b1;
					nxt_oe_n = 1'b1;
					nxt_cnt = 8'h00;
					if (!is_write_ff) begin
						nxt_rdata = data_in;
						if (ph_ff == SEQ_XFER)
							nxt_shift = {data_in[0], shift_ff[63:1]};
					end
					nxt_st = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				nxt_dq_oe = 1'b0;
				nxt_cnt = cnt_ff + 8'h01;
				if ({24'h0, cnt_ff} + 32'd1 >= RECOVER_CYCLES) begin
					nxt_st = ST_DONE;
				end
			end
			ST_DONE: begin
				nxt_st = ST_SETUP;
				case (ph_ff)
					SEQ_NONE: begin
						nxt_st = ST_IDLE;
						nxt_valid = 1'b1;
					end
					SEQ_OPEN: begin
						// pattern bits go out LSB first
						nxt_ph = SEQ_PATTERN;
						nxt_bit = 7'h00;
						nxt_is_write = 1'b1;
						nxt_dout = {7'h00, UNLOCK_PATTERN[0]};
					end
					SEQ_PATTERN: begin
						if (bit_ff == 7'd63) begin
							// switch to transfer after the 64th write
							nxt_ph = SEQ_XFER;
							nxt_bit = 7'h00;
							nxt_is_write = (op_ff == OP_CLOCK_WRITE);
							nxt_dout = {7'h00, shift_ff[0]};
						end else begin
							nxt_bit = bit_ff + 7'h01;
							nxt_dout = {7'h00, UNLOCK_PATTERN[nxt_bit[5:0]]};
						end
					end
					default: begin
						// 64 bits, eight whole bytes, cut short only by power fail
						if (is_write_ff)
							nxt_shift = {1'b0, shift_ff[63:1]};
						if (bit_ff == 7'd63) begin
							nxt_st = ST_IDLE;
							nxt_valid = 1'b1;
							nxt_ph = SEQ_NONE;
							if (!is_write_ff)
								nxt_crdata = shift_ff;
						end else begin
							nxt_bit = bit_ff + 7'h01;
							nxt_dout = {7'h00, shift_ff[1]};
						end
					end
				endcase
				if (ph_ff == SEQ_NONE && is_write_ff)
					nxt_dout = wdata_ff;
				if (pf_ff && ph_ff != SEQ_NONE) begin
					// abandon the sequence; device ignores it anyway
					nxt_st = ST_IDLE;
					nxt_valid = 1'b1;
					nxt_blocked = 1'b1;
					nxt_ph = SEQ_NONE;
				end
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
		if (st_ff == ST_IDLE && nxt_st == ST_SETUP && req_op == OP_MEM_WRITE)
			nxt_dout = req_wdata;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_ff <= ST_IDLE;
			ph_ff <= SEQ_NONE;
			op_ff <= OP_MEM_READ;
			cnt_ff <= 8'h00;
			bit_ff <= 7'h00;
			shift_ff <= 64'h0;
			addr_ff <= 21'h000000;
			wdata_ff <= 8'h00;
			is_write_ff <= 1'b0;
			req_ready_ff <= 1'b0;
			chip_sel_n_ff <= 1'b1;
			write_en_n_ff <= 1'b1;
			out_en_n_ff <= 1'b1;
			data_oe_ff <= 1'b0;
			data_out_ff <= 8'h00;
			resp_valid_ff <= 1'b0;
			resp_blocked_ff <= 1'b0;
			resp_rdata_ff <= 8'h00;
			clock_rdata_ff <= 64'h0;
		end else begin
			st_ff <= nxt_st;
			ph_ff <= nxt_ph;
			op_ff <= nxt_op;
			cnt_ff <= nxt_cnt;
			bit_ff <= nxt_bit;
			shift_ff <= nxt_shift;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			is_write_ff <= nxt_is_write;
			req_ready_ff <= nxt_ready;
			chip_sel_n_ff <= nxt_cs_n;
			write_en_n_ff <= nxt_we_n;
			out_en_n_ff <= nxt_oe_n;
			data_oe_ff <= nxt_dq_oe;
			data_out_ff <= nxt_dout;
			resp_valid_ff <= nxt_valid;
			resp_blocked_ff <= nxt_blocked;
			resp_rdata_ff <= nxt_rdata;
			clock_rdata_ff <= nxt_crdata;
		end
	end

	assign byte_address_lines_ff = addr_ff;
	logic unused_img;
	assign unused_img = ^img_rd;
endmodule

// ==== nvsram_host_sva.sv ====
/*
 Concurrent checks on the pins and handshake of the NV SRAM host controller.
 Assumes it is bound into nvsram_host and sees only that module's ports.
*/
`timescale 1ns/1ps
module nvsram_host_checker (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// User side
	input wire logic resp_valid_ff,
	input wire logic resp_blocked_ff,
	input wire logic power_fail_threshold,
	// Device pins
	input wire logic chip_sel_n_ff,
	input wire logic write_en_n_ff,
	input wire logic out_en_n_ff,
	input wire logic [20:0] byte_address_lines_ff,
	input wire logic data_oe_ff
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	read_strobe_a: assert property (!out_en_n_ff |-> !chip_sel_n_ff && write_en_n_ff)
		else $error("output enable low outside a selected read");
	write_pair_a: assert property ($changed(write_en_n_ff) |-> $changed(chip_sel_n_ff))
		else $error("write strobe moved without chip select");
	addr_hold_a: assert property (!write_en_n_ff && $past(!write_en_n_ff) |-> $stable(byte_address_lines_ff))
		else $error("address changed inside a write");
	write_recovery_a: assert property ($rose(write_en_n_ff) |-> chip_sel_n_ff ##1 chip_sel_n_ff)
		else $error("next cycle started without write recovery");
	write_drive_a: assert property (!write_en_n_ff |-> out_en_n_ff && data_oe_ff)
		else $error("write without host drive or with output enable low");
	read_float_a: assert property (!out_en_n_ff |-> !data_oe_ff)
		else $error("host drives data while device outputs enabled");
	// Counts cycles of power fail; the host may still finish the bus cycle under way
	logic [3:0] pf_run_ff, nxt_pf_run;
	always_comb begin
		nxt_pf_run = pf_run_ff;
		if (!power_fail_threshold)
			nxt_pf_run = 4'h0;
		else if (pf_run_ff != 4'hF)
			nxt_pf_run = pf_run_ff + 4'h1;
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			pf_run_ff <= 4'h0;
		else
			pf_run_ff <= nxt_pf_run;
	end
	pf_lockout_a: assert property (pf_run_ff == 4'hF |-> chip_sel_n_ff)
		else $error("device selected during power fail");
	pf_blocked_a: assert property ($rose(resp_blocked_ff) |-> resp_valid_ff)
		else $error("blocked flag without response");
endmodule
bind nvsram_host nvsram_host_checker nvsram_host_checker_i (.ref_clk, .rst, .resp_valid_ff,
	.resp_blocked_ff, .power_fail_threshold, .chip_sel_n_ff, .write_en_n_ff, .out_en_n_ff,
	.byte_address_lines_ff, .data_oe_ff);

// ==== nvsram_dev_model.sv ====
/*
 Behavioural NV SRAM with hidden timekeeper, reacting to pin edges only.
 Assumes strobes come from registers; resolves the data bus for the host.
*/
`timescale 1ns/1ps
module nvsram_dev_model #(
	parameter logic [63:0] PATTERN = 64'h0
) (
	// Device pins
	input wire logic chip_sel_n,
	input wire logic write_en_n,
	input wire logic out_en_n,
	input wire logic [20:0] addr,
	input wire logic [7:0] host_d,
	input wire logic host_oe,
	input wire logic power_fail,
	// Resolved bus
	output logic [7:0] bus
);
	logic [7:0] mem [logic [20:0]];
	logic [63:0] clk_bits;
	logic [7:0] last;
	logic [7:0] q;
	logic armed = 1'b0;
	int ptr = 0;
	int xfer = 0;
	// Inertial delay filters strobe skew inside one time step
	wire #1 wr_act = !chip_sel_n && !write_en_n && !power_fail;
	wire #1 rd_act = !chip_sel_n && write_en_n && !power_fail;
	wire dev_oe = rd_act && !out_en_n;
	always @(addr, xfer, dev_oe) begin
		if (xfer > 0) q = {7'h00, clk_bits[64 - xfer]};
		else q = mem.exists(addr) ? mem[addr] : 8'h00;
	end
	// Released bus shows the inverse of the last value, never a held copy
	assign bus = host_oe ? host_d : (dev_oe ? q : ~last);
	always @(host_oe, dev_oe, bus) if (host_oe || dev_oe) last = bus;
	always @(negedge wr_act) if (!power_fail) begin
		if (xfer > 0) begin
			clk_bits[64 - xfer] = host_d[0];
			xfer--;
		end else begin
			mem[addr] = host_d;
			if (armed && addr <= 21'h07FFFF && host_d[0] == PATTERN[ptr]) begin
				ptr++;
				if (ptr == 64) xfer = 64;
			end else armed = 1'b0;
			if (ptr == 64) armed = 1'b0;
		end
	end
	always @(negedge rd_act) if (!power_fail) begin
		if (xfer > 0) xfer--;
		else begin
			armed = 1'b1;
			ptr = 0;
		end
	end
endmodule

// ==== nvsram_hidden_clock_access_test.sv ====
/*
 Self-checking bench: host controller against the behavioural device model.
 Assumes shortened strobe timing parameters; random data from a fixed seed.
*/
`timescale 1ns/1ps
module nvsram_hidden_clock_access_test;
	import nvsram_host_pkg::*;
	localparam logic [63:0] PAT = 64'hC3A50F961E7BD248;
	localparam logic [20:0] SCRATCH = 21'h07FFFF;
	logic ref_clk, rst, req_valid, req_ready_ff, resp_valid_ff, resp_blocked_ff, pf;
	logic cs_n, we_n, oe_n, data_oe;
	host_op_t req_op;
	logic [20:0] req_addr, pin_addr;
	logic [7:0] req_wdata, resp_rdata_ff, data_in, data_out;
	logic [63:0] clock_wdata, clock_rdata_ff, w;
	logic [7:0] exp_mem [logic [20:0]];
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	nvsram_host #(.UNLOCK_PATTERN(PAT), .SCRATCH_ADDR(SCRATCH), .ACCESS_CYCLES(3),
		.PULSE_CYCLES(2), .RECOVER_CYCLES(1)) nvsram_host_i (.ref_clk, .rst, .req_valid,
		.req_op, .req_addr, .req_wdata, .clock_wdata, .req_ready_ff, .resp_valid_ff,
		.resp_rdata_ff, .clock_rdata_ff, .resp_blocked_ff, .power_fail_threshold(pf),
		.chip_sel_n_ff(cs_n), .write_en_n_ff(we_n), .out_en_n_ff(oe_n),
		.byte_address_lines_ff(pin_addr), .data_in, .data_out_ff(data_out), .data_oe_ff(data_oe));
	nvsram_dev_model #(.PATTERN(PAT)) nvsram_dev_model_i (.chip_sel_n(cs_n), .write_en_n(we_n),
		.out_en_n(oe_n), .addr(pin_addr), .host_d(data_out), .host_oe(data_oe),
		.power_fail(pf), .bus(data_in));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic results();
		$display("total_checks=%0d miscompares=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			results();
		end
	end
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_word(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Request held until the accepting edge, then wait for the one-cycle response
	task automatic run_op(input host_op_t op, input logic [20:0] a, input logic [7:0] d,
		input logic [63:0] cw);
		int n;
		n = 0;
		@(negedge ref_clk);
		while (req_ready_ff !== 1'b1 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		req_valid = 1'b1;
		req_op = op;
		req_addr = a;
		req_wdata = d;
		clock_wdata = cw;
		@(negedge ref_clk);
		req_valid = 1'b0;
		while (resp_valid_ff !== 1'b1 && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 3000) check_byte(8'h00, 8'hFF);
	endtask
	initial begin
		logic [20:0] a;
		logic [7:0] d;
		rst = 1'b1;
		pf = 1'b0;
		req_valid = 1'b0;
		req_op = OP_MEM_READ;
		req_addr = 21'h000000;
		req_wdata = 8'h00;
		clock_wdata = 64'h0;
		void'($urandom(67));
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		pf = 1'b0;
		// Power-fail synchroniser leaves reset reading failing; let it clear first
		repeat (4) @(negedge ref_clk);
		for (int k = 0; k < 9; k++) begin
			a = (k == 0) ? 21'h000000 : (k == 1) ? 21'h1FFFFF : 21'($urandom());
			d = 8'($urandom());
			run_op(OP_MEM_WRITE, a, d, 64'h0);
			exp_mem[a] = d;
		end
		w = {$urandom(), $urandom()};
		fork
			run_op(OP_CLOCK_WRITE, 21'h000000, 8'h00, w);
			begin
				repeat (60) @(negedge ref_clk);
				pf = 1'b1;
			end
		join
		check_byte({7'h00, resp_blocked_ff}, 8'h01);
		pf = 1'b0;
		repeat (4) @(negedge ref_clk);
		for (int k = 0; k < 2; k++) begin
			w = (k == 0) ? {$urandom(), $urandom()} : ~w;
			run_op(OP_CLOCK_WRITE, 21'h000000, 8'h00, w);
			run_op(OP_CLOCK_READ, 21'h000000, 8'h00, 64'h0);
			check_word(clock_rdata_ff, w);
		end
		run_op(OP_MEM_READ, SCRATCH, 8'h00, 64'h0);
		check_byte(resp_rdata_ff, {7'h00, PAT[63]});
		if (exp_mem.exists(SCRATCH)) exp_mem[SCRATCH] = {7'h00, PAT[63]};
		pf = 1'b1;
		// Two synchroniser stages must see the failure before the request is taken
		repeat (3) @(negedge ref_clk);
		run_op(OP_MEM_WRITE, 21'h000000, ~exp_mem[21'h000000], 64'h0);
		check_byte({7'h00, resp_blocked_ff}, 8'h01);
		pf = 1'b0;
		repeat (4) @(negedge ref_clk);
		foreach (exp_mem[x]) begin
			run_op(OP_MEM_READ, x, 8'h00, 64'h0);
			check_byte(resp_rdata_ff, exp_mem[x]);
			check_byte({7'h00, resp_blocked_ff}, 8'h00);
		end
		results();
	end
endmodule
